// ### hw/rwdt_top.sv
// runaway watchdog: 22-stage counter, command register, overflow interrupt,
// active-low fault output and optional internal reset; registers over AHB-Lite
// assumes halt mode and bus grant arrive asynchronously from the clock controller
`timescale 1ns/1ps
`include "rwdt_map.svh"
module rwdt_top
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // register bus
  input wire rwdt_pkg::rwdt_ahb_req_t ahbReq,
  output rwdt_pkg::rwdt_ahb_rsp_t ahbRsp,
  // chip side
  input wire rwdt_pkg::rwdt_halt_t haltMode,
  input wire logic busGrantAck_n,
  output logic wdtOverflowIrq,
  output logic wdtFaultOut_n,
  output logic intReset_n,
  output logic irq
);
  import rwdt_pkg::*;

  rwdt_state_t s_q;
  rwdt_state_t s_d;
  logic [21:0] detectTap;
  logic cntRun;
  logic overflow;
  logic cmdWr;
  logic [7:0] wrByte;

  // outputs come straight from flip-flops
  assign ahbRsp = s_q.rsp;
  assign wdtOverflowIrq = s_q.ovfIrq;
  assign wdtFaultOut_n = s_q.faultN;
  assign intReset_n = s_q.intResetN;
  assign irq = s_q.irq;

  // detection tap: the counter value at which overflow fires
  always_comb
  begin
    unique case (s_q.mode.period)
      2'd0: detectTap = 22'h007fff;
      2'd1: detectTap = 22'h01ffff;
      2'd2: detectTap = 22'h07ffff;
      default: detectTap = 22'h1fffff;
    endcase
  end

  // halt modes gate counting; bus grant deliberately does not
  always_comb
  begin
    unique case (rwdt_halt_t'(s_q.haltSync2))
      RWDT_RUN: cntRun = s_q.running;
      RWDT_PROG_HALT: cntRun = s_q.running && s_q.mode.progHaltRun;
      default: cntRun = 1'b0;
    endcase
  end

  assign overflow = cntRun && (s_q.count == detectTap);
  assign wrByte = ahbReq.hwdata[7:0];
  assign cmdWr = s_q.wrPend && (s_q.wrAddr == `RWDT_OFS_CMD);

  // next state
  always_comb
  begin
    s_d = s_q;
    // synchronisers: second stage reads first, nothing else does
    s_d.haltSync1 = haltMode;
    s_d.haltSync2 = s_q.haltSync1;
    s_d.ackSync1 = busGrantAck_n;
    s_d.ackSync2 = s_q.ackSync1;
    s_d.ovfIrq = 1'b0;

    // bus: zero-wait slave, OKAY always
    s_d.rsp.hreadyout = 1'b1;
    s_d.rsp.hresp = 1'b0;
    s_d.wrPend = 1'b0;
    if (ahbReq.hsel && ahbReq.hready && ahbReq.htrans[1])
    begin
      s_d.wrPend = ahbReq.hwrite;
      s_d.wrAddr = ahbReq.haddr[7:0];
      s_d.rsp.hrdata = 32'h0000_0000;
      if (!ahbReq.hwrite)
      begin
        unique case (ahbReq.haddr[7:0])
          `RWDT_OFS_MODE:
          begin
            s_d.rsp.hrdata[`RWDT_MODE_ENABLE] = s_q.mode.armed;
            s_d.rsp.hrdata[`RWDT_MODE_PER_HI:`RWDT_MODE_PER_LO] = s_q.mode.period;
            s_d.rsp.hrdata[`RWDT_MODE_PHALT] = s_q.mode.progHaltRun;
            s_d.rsp.hrdata[`RWDT_MODE_RESLINK] = s_q.mode.resetLink;
          end
          `RWDT_OFS_STATUS:
          begin
            s_d.rsp.hrdata[1:0] = s_q.status;
            s_d.status = 2'b00; // read clears; new events below still win
          end
          `RWDT_OFS_MASK: s_d.rsp.hrdata[1:0] = s_q.mask;
          `RWDT_OFS_COUNT: s_d.rsp.hrdata[21:0] = s_q.count;
          default: s_d.rsp.hrdata = 32'h0000_0000; // command and unmapped read zero
        endcase
      end
    end

    // data phase of a write
    if (s_q.wrPend)
    begin
      unique case (s_q.wrAddr)
        `RWDT_OFS_MODE:
        begin
          s_d.mode.armed = wrByte[`RWDT_MODE_ENABLE];
          s_d.mode.period = wrByte[`RWDT_MODE_PER_HI:`RWDT_MODE_PER_LO];
          s_d.mode.progHaltRun = wrByte[`RWDT_MODE_PHALT];
          s_d.mode.resetLink = wrByte[`RWDT_MODE_RESLINK];
          if (wrByte[`RWDT_MODE_ENABLE])
            s_d.running = 1'b1;
        end
        `RWDT_OFS_MASK: s_d.mask = wrByte[1:0];
        default: ;
      endcase
    end

    // counting
    if (!cntRun)
    begin
      if (rwdt_halt_t'(s_q.haltSync2) inside {RWDT_LIGHT_HALT, RWDT_STOP})
        s_d.count = 22'h000000;
    end
    else if (overflow)
      s_d.count = 22'h000000;
    else
      s_d.count = s_q.count + 22'h000001;

    // overflow effects
    if (overflow)
    begin
      s_d.faultN = 1'b0;
      s_d.ovfIrq = 1'b1;
      s_d.status[`RWDT_ST_OVF] = 1'b1;
      if (s_q.mode.resetLink)
      begin
        s_d.rstCnt = `RWDT_RST_CYC;
        s_d.intResetN = 1'b0;
        s_d.status[`RWDT_ST_RST] = 1'b1;
      end
    end

    // command register: clear and guarded disable, anything else ignored
    if (cmdWr)
    begin
      if (wrByte == `RWDT_CODE_CLEAR)
      begin
        s_d.count = 22'h000000;
        s_d.faultN = 1'b1;
      end
      else if (wrByte == `RWDT_CODE_DISABLE && !s_q.mode.armed)
      begin
        s_d.running = 1'b0;
        s_d.count = 22'h000000;
      end
      // other codes fall through untouched
    end

    // internal reset pulse length
    if (s_q.rstCnt != 5'd0)
    begin
      s_d.rstCnt = s_q.rstCnt - 5'd1;
      if (s_q.rstCnt == 5'd1)
        s_d.intResetN = 1'b1;
    end

    s_d.irq = |(s_d.status & s_d.mask);
  end

  // single state register; the counter starts right after reset release
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_q <= '0;
      s_q.rsp.hreadyout <= 1'b1;
      s_q.mode.armed <= 1'b1;
      s_q.running <= 1'b1;
      s_q.faultN <= 1'b1;
      s_q.intResetN <= 1'b1;
      s_q.ackSync1 <= 1'b1;
      s_q.ackSync2 <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // checks
  a_enable_reset: assert property (@(posedge ref_clk) $rose(reset_n) |-> s_q.mode.armed && s_q.running)
    else $error("watchdog not armed after reset");
  a_disable_guard: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $fell(s_q.running) |-> $past(cmdWr) && $past(wrByte) == 8'hb1 && !$past(s_q.mode.armed))
    else $error("watchdog stopped without guarded sequence");
  a_enable_resume: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_q.wrPend && s_q.wrAddr == 8'h00 && wrByte[7] |=> s_q.running)
    else $error("enable did not resume watchdog");
  a_reset_link: assert property (@(posedge ref_clk) disable iff (!reset_n)
    overflow && !s_q.mode.resetLink && s_q.rstCnt == 5'd0 |=> intReset_n)
    else $error("internal reset without link");
  a_clear_code: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cmdWr && wrByte == 8'h4e |=> s_q.count == 22'h0 && wdtFaultOut_n)
    else $error("clear code did not clear counter");
  a_overflow_out: assert property (@(posedge ref_clk) disable iff (!reset_n)
    overflow && !(cmdWr && wrByte == 8'h4e) |=> wdtOverflowIrq && !wdtFaultOut_n)
    else $error("overflow did not signal");
  a_halt_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_q.haltSync2 == 2'd1 |=> s_q.count == 22'h0)
    else $error("counter ran in light halt");
  a_grant_count: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !s_q.ackSync2 && cntRun && !overflow && !cmdWr |=> s_q.count == $past(s_q.count) + 22'h1)
    else $error("counter stalled during bus grant");
  a_phalt_stop: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_q.haltSync2 == 2'd2 && !s_q.mode.progHaltRun && !cmdWr |=> $stable(s_q.count))
    else $error("counter ran in programmable halt");
  a_fault_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !wdtFaultOut_n && !(cmdWr && wrByte == 8'h4e) |=> !wdtFaultOut_n)
    else $error("fault output released without clear");
  a_reset_len: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $fell(intReset_n) |-> !intReset_n [*8] ##18 intReset_n)
    else $error("internal reset length wrong");
  a_other_code: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cmdWr && wrByte != 8'h4e && wrByte != 8'hb1 && !cntRun |=> $stable(s_q.count) && $stable(s_q.running))
    else $error("other command changed state");

  // the slave never stalls and never errors, so masters need no retry path
  a_bus_okay: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ahbRsp.hreadyout && !ahbRsp.hresp)
    else $error("bus answer not ready or not okay");

  // interrupt level follows the registered status and mask
  a_irq_level: assert property (@(posedge ref_clk) disable iff (!reset_n)
    irq == |(s_q.status & s_q.mask))
    else $error("interrupt level disagrees with status and mask");

  // the overflow interrupt is a single-cycle pulse since the counter restarts at zero
  a_ovf_pulse: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wdtOverflowIrq |=> !wdtOverflowIrq)
    else $error("overflow pulse longer than one cycle");

  // an overflow always leaves its sticky bit, even against a status read
  a_ovf_status: assert property (@(posedge ref_clk) disable iff (!reset_n)
    overflow |=> s_q.status[0])
    else $error("overflow status not set");

  // a linked overflow records the reset and pulls the internal reset low
  a_link_status: assert property (@(posedge ref_clk) disable iff (!reset_n)
    overflow && s_q.mode.resetLink |=> s_q.status[1] && !intReset_n)
    else $error("linked overflow gave no internal reset");

  // shortest detection time
  a_tap_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
    overflow && s_q.mode.period == 2'd0 |-> s_q.count == 22'h007fff)
    else $error("overflow at wrong count for period 0");

  // second detection time
  a_tap_one: assert property (@(posedge ref_clk) disable iff (!reset_n)
    overflow && s_q.mode.period == 2'd1 |-> s_q.count == 22'h01ffff)
    else $error("overflow at wrong count for period 1");

  // third detection time
  a_tap_two: assert property (@(posedge ref_clk) disable iff (!reset_n)
    overflow && s_q.mode.period == 2'd2 |-> s_q.count == 22'h07ffff)
    else $error("overflow at wrong count for period 2");

  // longest detection time uses the lower 21 stages; the top stage sets only if a shorter period is written while the count is past its tap
  a_tap_three: assert property (@(posedge ref_clk) disable iff (!reset_n)
    overflow && s_q.mode.period == 2'd3 |-> s_q.count == 22'h1fffff)
    else $error("overflow at wrong count for period 3");

  // after an overflow the count starts again from zero
  a_count_wrap: assert property (@(posedge ref_clk) disable iff (!reset_n)
    overflow |=> s_q.count == 22'h000000)
    else $error("counter did not wrap after overflow");

  // a running counter steps by exactly one per clock
  a_count_step: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cntRun && !overflow && !cmdWr |=> s_q.count == $past(s_q.count) + 22'h000001)
    else $error("counter did not step by one");

  // a disabled watchdog in run mode keeps its count frozen
  a_stop_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !s_q.running && s_q.haltSync2 == 2'd0 && !cmdWr |=> $stable(s_q.count))
    else $error("disabled counter moved");

  // stop mode holds the counter at zero
  a_stop_mode: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_q.haltSync2 == 2'd3 |=> s_q.count == 22'h000000)
    else $error("counter ran in stop mode");

  // the internal reset only ever falls after a linked overflow
  a_reset_cause: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $fell(intReset_n) |-> $past(overflow) && $past(s_q.mode.resetLink))
    else $error("internal reset without linked overflow");

  // the fault output only falls on an overflow
  a_fault_fall: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $fell(wdtFaultOut_n) |-> $past(overflow))
    else $error("fault output fell without overflow");

  // the fault output only rises on the clear code
  a_fault_rise: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(wdtFaultOut_n) |-> $past(cmdWr) && $past(wrByte) == 8'h4e)
    else $error("fault output released without clear code");

  // a stopped watchdog restarts only through the enable bit
  a_resume_cause: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(s_q.running) |-> $past(s_q.wrPend) && $past(s_q.wrAddr) == 8'h00 && $past(wrByte[7]))
    else $error("watchdog resumed without enable write");

  // mask writes land in the data phase
  a_mask_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_q.wrPend && s_q.wrAddr == 8'h0c |=> s_q.mask == $past(wrByte[1:0]))
    else $error("mask write did not land");

  // the reset-link bit takes the written value
  a_link_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_q.wrPend && s_q.wrAddr == 8'h00 |=> s_q.mode.resetLink == $past(wrByte[1]))
    else $error("reset link write did not land");

  // reading status clears it unless a new event arrives in the same cycle
  a_read_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ahbReq.hsel && ahbReq.hready && ahbReq.htrans[1] && !ahbReq.hwrite && ahbReq.haddr[7:0] == 8'h08
    && !overflow |=> s_q.status == 2'b00)
    else $error("status read did not clear");
endmodule

// ### include/rwdt_map.svh
// register offsets, field positions, reset values and timing counts of the watchdog
// assumes a 32-bit AHB-Lite register bus, one aligned word per register
`ifndef RWDT_MAP_SVH
`define RWDT_MAP_SVH

// byte offsets
`define RWDT_OFS_MODE 8'h00
`define RWDT_OFS_CMD 8'h04
`define RWDT_OFS_STATUS 8'h08
`define RWDT_OFS_MASK 8'h0c
`define RWDT_OFS_COUNT 8'h10

// mode register fields
`define RWDT_MODE_ENABLE 7
`define RWDT_MODE_PER_HI 6
`define RWDT_MODE_PER_LO 5
`define RWDT_MODE_PHALT 2
`define RWDT_MODE_RESLINK 1
`define RWDT_MODE_RESET 8'h80

// command codes
`define RWDT_CODE_CLEAR 8'h4e
`define RWDT_CODE_DISABLE 8'hb1

// status / mask fields
`define RWDT_ST_OVF 0
`define RWDT_ST_RST 1

// counter and internal reset length
`define RWDT_CNT_W 22
`define RWDT_RST_CYC 5'd25

`endif

// ### include/rwdt_pkg.sv
// types shared by the watchdog design
// assumes the map header supplies the numeric constants
package rwdt_pkg;

  typedef enum logic [1:0] {
    RWDT_RUN,
    RWDT_LIGHT_HALT,
    RWDT_PROG_HALT,
    RWDT_STOP
  } rwdt_halt_t;

  // AHB-Lite slave request side
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
    logic [31:0] hwdata;
  } rwdt_ahb_req_t;

  // AHB-Lite slave answer side
  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } rwdt_ahb_rsp_t;

  typedef struct packed {
    logic armed;
    logic [1:0] period;
    logic progHaltRun;
    logic resetLink;
  } rwdt_mode_t;

  typedef struct packed {
    rwdt_ahb_rsp_t rsp;
    logic wrPend;
    logic [7:0] wrAddr;
    rwdt_mode_t mode;
    logic running;
    logic [21:0] count;
    logic faultN;
    logic [1:0] status;
    logic [1:0] mask;
    logic irq;
    logic ovfIrq;
    logic [4:0] rstCnt;
    logic intResetN;
    logic [1:0] haltSync1;
    logic [1:0] haltSync2;
    logic ackSync1;
    logic ackSync2;
  } rwdt_state_t;

endpackage

// ### bench/rwdt_reset_model.sv
// peripheral reset circuit model: measures each low pulse of the internal reset
// assumes intReset_n is a registered level on ref_clk
`timescale 1ns/1ps
module rwdt_reset_model
(
  // clock
  input wire logic ref_clk,
  // watched reset line
  input wire logic intReset_n,
  // length of the last low pulse
  output int lowLen
);
  int run = 0;
  initial lowLen = 0;
  // publish only on release, so a line stuck low never reports a length
  always @(posedge ref_clk)
  begin
    if (intReset_n === 1'b0)
      run <= run + 1;
    else if (run != 0)
    begin
      lowLen <= run;
      run <= 0;
    end
  end
endmodule

// ### bench/runaway_watchdog_timer_bench.sv
// self-checking bench for the runaway watchdog over its AHB-Lite registers
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ps
`include "rwdt_map.svh"
module runaway_watchdog_timer_bench;
  import rwdt_pkg::*;
  logic ref_clk = 0;
  logic reset_n = 0;
  rwdt_ahb_req_t busReq = '0;
  rwdt_ahb_req_t ahbReq;
  rwdt_ahb_rsp_t ahbRsp;
  rwdt_halt_t haltMode = RWDT_RUN;
  logic busGrantAck_n = 1;
  logic wdtOverflowIrq, wdtFaultOut_n, intReset_n, irq;
  int lowLen;
  int numErrors = 0;
  int checkCount = 0;
  logic [31:0] c1, c2, rd;

  always #2.5 ref_clk = ~ref_clk;
  // the one slave drives the bus ready
  always_comb
  begin
    ahbReq = busReq;
    ahbReq.hready = ahbRsp.hreadyout;
  end

  rwdt_top u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .ahbReq(ahbReq), .ahbRsp(ahbRsp),
    .haltMode(haltMode), .busGrantAck_n(busGrantAck_n), .wdtOverflowIrq(wdtOverflowIrq),
    .wdtFaultOut_n(wdtFaultOut_n), .intReset_n(intReset_n), .irq(irq));
  rwdt_reset_model u_rst (.ref_clk(ref_clk), .intReset_n(intReset_n), .lowLen(lowLen));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic printVerdict();
    $display("checks %0d mismatches %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // ready is sampled at the edge; the watchdog below bounds a stall
  task automatic waitReady();
    do @(posedge ref_clk); while (ahbRsp.hreadyout !== 1'b1);
  endtask

  // one single transfer; a spare edge after it keeps drivers from double assigning
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    busReq.hsel <= 1'b1;
    busReq.haddr <= {24'h0, a};
    busReq.htrans <= 2'b10;
    busReq.hwrite <= w;
    busReq.hsize <= 3'b010;
    waitReady();
    busReq.hsel <= 1'b0;
    busReq.htrans <= 2'b00;
    busReq.hwdata <= d;
    waitReady();
    r = ahbRsp.hrdata;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask

  task automatic cnt(output logic [31:0] v);
    bus(1'b0, `RWDT_OFS_COUNT, 32'h0, v);
  endtask

  // reset values of mode and mask
  task automatic testReset();
    bus(1'b0, `RWDT_OFS_MODE, 32'h0, rd);
    check(rd, 32'h80);
    bus(1'b0, `RWDT_OFS_MASK, 32'h0, rd);
    check(rd, 32'h0);
    check(32'(wdtFaultOut_n), 32'h1);
  endtask

  // free running count, foreign code ignored, clear code restarts from zero
  task automatic testClear();
    cnt(c1);
    check(32'(c1 > 32'd20), 32'h1);
    busGrantAck_n <= 1'b0;
    wr(`RWDT_OFS_CMD, 32'h55);
    cnt(c2);
    check(32'(c2 > c1), 32'h1);
    wr(`RWDT_OFS_CMD, `RWDT_CODE_CLEAR);
    cnt(c1);
    check(32'(c1 < 32'd8), 32'h1);
    busGrantAck_n <= 1'b1;
  endtask

  // each disable step alone keeps counting; enable bit alone restarts
  task automatic testDisable();
    wr(`RWDT_OFS_CMD, `RWDT_CODE_DISABLE);
    wr(`RWDT_OFS_MODE, 32'h00);
    cnt(c1);
    cnt(c2);
    check(32'(c2 > c1), 32'h1);
    wr(`RWDT_OFS_CMD, `RWDT_CODE_DISABLE);
    cnt(c1);
    wr(`RWDT_OFS_CMD, 32'h55);
    idle(10);
    cnt(c2);
    check(c2, c1);
    wr(`RWDT_OFS_MODE, 32'h80);
    cnt(c2);
    check(32'(c2 > c1), 32'h1);
  endtask

  // deep halts hold the counter at zero; the programmable halt obeys its bit
  task automatic testHalt();
    for (int i = 0; i < 2; i++)
    begin
      haltMode <= i ? RWDT_STOP : RWDT_LIGHT_HALT;
      idle(4);
      cnt(c1);
      check(c1, 32'h0);
    end
    wr(`RWDT_OFS_MODE, 32'h84);
    haltMode <= RWDT_PROG_HALT;
    idle(4);
    cnt(c1);
    cnt(c2);
    check(32'(c2 > c1), 32'h1);
    wr(`RWDT_OFS_MODE, 32'h80);
    idle(4);
    cnt(c1);
    idle(5);
    cnt(c2);
    check(c2, c1);
    haltMode <= RWDT_RUN;
  endtask

  // overflow at the shortest tap with the reset link set
  task automatic testOverflow();
    int n;
    n = 0;
    wr(`RWDT_OFS_MASK, 32'h3);
    wr(`RWDT_OFS_MODE, 32'h82);
    wr(`RWDT_OFS_CMD, `RWDT_CODE_CLEAR);
    while (wdtOverflowIrq !== 1'b1)
    begin
      n++;
      @(posedge ref_clk);
    end
    check(32'(n > 32760 && n < 32776), 32'h1);
    idle(2);
    check(32'(wdtFaultOut_n), 32'h0);
    check(32'(irq), 32'h1);
    wr(`RWDT_OFS_MASK, 32'h0);
    idle(2);
    check(32'(irq), 32'h0);
    wr(`RWDT_OFS_MASK, 32'h3);
    idle(40);
    check(32'(lowLen >= 22 && lowLen <= 29), 32'h1);
    check(32'(wdtFaultOut_n), 32'h0);
    bus(1'b0, `RWDT_OFS_STATUS, 32'h0, rd);
    check(rd, 32'h3);
    bus(1'b0, `RWDT_OFS_STATUS, 32'h0, rd);
    check(rd, 32'h0);
    check(32'(irq), 32'h0);
    wr(`RWDT_OFS_CMD, `RWDT_CODE_CLEAR);
    idle(2);
    check(32'(wdtFaultOut_n), 32'h1);
  endtask

  initial
  begin
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    idle(30);
    testReset();
    testClear();
    testDisable();
    testHalt();
    testOverflow();
    printVerdict();
  end

  // the whole run needs about 33000 cycles; cut a hang well beyond that
  initial
  begin
    #400000;
    numErrors++;
    printVerdict();
  end
endmodule
